// File: hdl/mscfg_defines.svh
// Purpose: constants of the MAC-side frame configuration block
// Assumes: included by the package only
// Notes:   register locations are a 4-bit type and a 3-bit index
`ifndef MSCFG_DEFINES_SVH
`define MSCFG_DEFINES_SVH

`define MSCFG_T_CTL      4'h1
`define MSCFG_T_HDR      4'h2
`define MSCFG_T_BUF      4'h3
`define MSCFG_T_THR      4'h4
`define MSCFG_T_CAP      4'h5
`define MSCFG_T_QUOTA    4'hC
`define MSCFG_I_TXCTL    3'h0
`define MSCFG_I_RXCTL    3'h1
`define MSCFG_I_FIFO_A   3'h4
`define MSCFG_I_RX_HI    2'h2
`define MSCFG_CAP_COUNT  3'h6

`define MSCFG_TX_ON      0
`define MSCFG_RX_PARITY  7
`define MSCFG_RX_SPLIT   6
`define MSCFG_RX_OWN     5
`define MSCFG_RX_ALL     4
`define MSCFG_RX_CRC     3
`define MSCFG_RX_SHARED  2
`define MSCFG_RX_B_ON    1
`define MSCFG_RX_A_ON    0

`define MSCFG_TXCTL_MASK  8'hFD
`define MSCFG_FILTER_MASK 8'hBF
`define MSCFG_CAP_MASK    8'h7F
`define MSCFG_FULL_MASK   8'hFF
`define MSCFG_RST_VALUE   8'h00
`define MSCFG_BUF_UNIT    14'h0040
`define MSCFG_HDR_UNIT    14'h0020
`define MSCFG_HOST_STATUS 8'h80

`endif

// File: hdl/mscfg_pkg.sv
// Purpose: types and shared decoding of the MAC-side frame configuration block
// Assumes: byte counts fit 14 bits (largest is 8K)
// Notes:   the controller end decodes register locations through these functions; the device end decodes them inline
package mscfg_pkg;
`include "mscfg_defines.svh"

	typedef logic [13:0] mscfg_bytes_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} mscfg_tx_t;
	typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_RECV = 3'b010, RX_DROP = 3'b100} mscfg_rx_t;

	typedef struct packed {
		logic [7:0][7:0] thr;
		logic [5:0][6:0] cap;
		logic [1:0][7:0] filt;
		logic [1:0][7:0] bufSz;
		logic [7:0]      hdr;
		logic [1:0][7:0] quota;
		logic [7:0]      txCtl;
		logic [7:0]      rxCtl;
		mscfg_tx_t       txSt;
		logic [5:0]      txStart;
		logic            txBusy;
		logic [5:0]      capReached;
		logic [1:0]      drainOk;
		logic [1:0]      quotaFull;
		mscfg_rx_t       rxSt;
		logic [2:0]      rxType;
		logic            toB;
		logic            inHdr;
		mscfg_bytes_t    cnt;
		mscfg_bytes_t    frameLength;
		logic            pushValid;
		logic            pushToB;
		logic [7:0]      pushData;
		logic            pushParity;
		logic            abortMac;
		logic            hdrRel;
		logic            hdrErr;
		logic            frameDone;
		logic            parErr;
		logic            abortSeen;
		logic [7:0]      status;
	} mscfg_dev_t;

	typedef struct packed {
		logic [127:0][7:0] shadow;
		logic              regWr;
		logic [3:0]        regType;
		logic [2:0]        regIndex;
		logic [7:0]        regData;
		logic              clearErrors;
		logic [7:0]        rdata;
	} mscfg_host_t;

	function automatic mscfg_bytes_t threshBytes(input logic [7:0] v);
		threshBytes = {1'b0, v, 5'h00};
	endfunction

	function automatic mscfg_bytes_t quotaBytes(input logic [7:0] v);
		logic [8:0] p;
		p = {1'b0, v} + 9'h001;
		quotaBytes = {p, 5'h00};
	endfunction

	// one-hot size field; several bits set give their OR, not a checked error
	function automatic mscfg_bytes_t sizeBytes(input logic [7:0] v, input mscfg_bytes_t unit);
		sizeBytes = '0;
		for (int i = 0; i < 8; i++) begin
			if (v[i]) begin
				sizeBytes = sizeBytes | (unit << i);
			end
		end
	endfunction

	function automatic logic validLoc(input logic [3:0] t, input logic [2:0] i);
		logic rx;
		rx = (i[2:1] == `MSCFG_I_RX_HI);
		if (t == `MSCFG_T_CTL) begin
			validLoc = rx || i == `MSCFG_I_TXCTL || i == `MSCFG_I_RXCTL;
		end else if (t == `MSCFG_T_HDR) begin
			validLoc = (i == `MSCFG_I_FIFO_A);
		end else if (t == `MSCFG_T_BUF || t == `MSCFG_T_QUOTA) begin
			validLoc = rx;
		end else if (t == `MSCFG_T_THR) begin
			validLoc = 1'b1;
		end else if (t == `MSCFG_T_CAP) begin
			validLoc = (i < `MSCFG_CAP_COUNT);
		end else begin
			validLoc = 1'b0;
		end
	endfunction

	function automatic logic [7:0] maskOf(input logic [3:0] t, input logic [2:0] i);
		if (t == `MSCFG_T_CTL && i == `MSCFG_I_TXCTL) begin
			maskOf = `MSCFG_TXCTL_MASK;
		end else if (t == `MSCFG_T_CTL && i[2:1] == `MSCFG_I_RX_HI) begin
			maskOf = `MSCFG_FILTER_MASK;
		end else if (t == `MSCFG_T_CAP) begin
			maskOf = `MSCFG_CAP_MASK;
		end else begin
			maskOf = `MSCFG_FULL_MASK;
		end
	endfunction
endpackage

// File: hdl/mscfg_link_if.sv
// Purpose: register path between the controller end and the MAC-side end
// Assumes: both ends on mclk
// Notes:   writes plus device status; the controller keeps a shadow for register reads
`timescale 1ns/1ps
interface mscfg_link_if;
	logic       regWr;
	logic [3:0] regType;
	logic [2:0] regIndex;
	logic [7:0] regData;
	logic       clearErrors;
	logic [7:0] devStatus;

	modport host (output regWr, regType, regIndex, regData, clearErrors, input devStatus);
	modport dev  (input regWr, regType, regIndex, regData, clearErrors, output devStatus);
endinterface

// File: hdl/mscfg_rx_steer.sv
// Purpose: picks the receive fifo for a frame type
// Assumes: type 7 is the token-cycle-end indication
// Notes:   purely combinational
`timescale 1ns/1ps
module mscfg_rx_steer import mscfg_pkg::*; (
	input  wire logic [2:0] frameType,   // received frame type
	input  wire logic [7:0] filterA,     // filter of fifo 4
	input  wire logic [7:0] filterB,     // filter of fifo 5
	input  wire logic       acceptA,     // fifo 4 enabled
	input  wire logic       acceptB,     // fifo 5 enabled
	input  wire logic       isOwn,       // frame sent by this station
	input  wire logic       ownOn,       // own-frame indications wanted
	input  wire logic       inHeader,    // header part of a split frame
	output logic            toB,         // destination is fifo 5
	output logic            store,       // frame admitted and fifo enabled
	output logic            abort        // admitted but fifo disabled
);
	logic inA;
	logic inB;
	logic admit;

	assign inA   = filterA[frameType];
	assign inB   = filterB[frameType];
	assign admit = (inA || inB) && (!isOwn || ownOn);
	// both set goes to fifo 4; split headers always do
	assign toB   = !inHeader && !inA && inB;
	assign store = admit && (toB ? acceptB : acceptA);
	assign abort = admit && !(toB ? acceptB : acceptA);
endmodule

// File: hdl/mscfg_device_end.sv
// Purpose: MAC-side configuration registers and frame control
// Assumes: MAC and fifo status inputs are on mclk
// Notes:   tx channels k=0..5 are channels 0,1,2,3,6,7
// Functional notes
// - threshold equals value times 32 bytes
// - transmit starts at threshold or whole frame
// - receive drain starts at threshold or frame
// - frame cap per channel is code plus one
// - filter bit set admits type into fifo
// - clear in both drops; both set: fifo 4
// - filter bits 0..5 select frame types
// - bit 7 selects token-cycle-end indications
// - buffer size is one-hot 64 bytes to 8K
// - zero with descriptor lengths; set for one-buffer
// - header size is one-hot 32 bytes to 4K
// - receive quota is value plus one times 32
// - global enable stops only after current frame
// - channel disables affect only their channel
// - parity checked and aborted, or generated
// - split header goes to fifo 4
// - own-frame indications routed by type when on
// - receive-all stores remnants, else valid only
// - CRC kept when asked, split or receive-all
// - one-buffer mode stores first buffer only
// - early release, else header held until end
// - disabled fifo not filled; MAC gets abort
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module mscfg_device_end import mscfg_pkg::*; (
	input  wire logic                mclk,            // clock, 100 MHz
	input  wire logic                rst,             // synchronous reset, high
	mscfg_link_if.dev                bus,             // register path
	input  wire logic [5:0]          txRequest,       // channel has a frame queued
	input  wire logic [5:0][13:0]    txFifoBytes,     // bytes held per tx fifo
	input  wire logic [5:0]          txWholeFrame,    // tx fifo holds whole frame
	input  wire logic                txFrameDone,     // MAC finished frame, pulse
	input  wire logic [5:0][7:0]     localFrames,     // frames in local memory
	input  wire logic [1:0][13:0]    rxFifoBytes,     // bytes held per rx fifo
	input  wire logic [1:0]          rxWholeFrame,    // rx fifo holds a frame
	input  wire logic [1:0][13:0]    rxRingUsed,      // memory used per rx ring
	input  wire logic                rxStart,         // frame begins, pulse
	input  wire logic [2:0]          rxType,          // frame type at start
	input  wire logic                rxOwn,           // own frame at start
	input  wire logic                rxRemnant,       // remnant frame at start
	input  wire logic                rxByteValid,     // byte present
	input  wire logic [7:0]          rxByte,          // received byte
	input  wire logic                rxParity,        // odd parity of byte
	input  wire logic                rxCrc,           // byte is part of CRC
	input  wire logic                rxEnd,           // frame ends, pulse
	input  wire logic                rxAborted,       // MAC aborted frame, pulse
	output logic [5:0]               txStart,         // start channel, pulse
	output logic                     txBusy,          // frame in progress
	output logic [5:0]               capReached,      // channel frame cap met
	output logic [1:0]               rxDrainOk,       // rx fifo may drain
	output logic [1:0]               quotaFull,       // rx ring at or over quota
	output logic                     pushValid,       // store byte, pulse
	output logic                     pushToB,         // store into fifo 5
	output logic [7:0]               pushData,        // stored byte
	output logic                     pushParity,      // stored parity
	output logic                     receiveAbortToMac, // abort to MAC, pulse
	output logic                     headerRelease,   // header released, pulse
	output logic                     headerError,     // header error, pulse
	output logic                     frameDone,       // frame stored, pulse
	output logic [13:0]              frameLength      // stored length
);
	mscfg_dev_t s;
	mscfg_dev_t n;
	logic [5:0] txReady;
	logic       stToB;
	logic       stStore;
	logic       stAbort;
	logic       idle;
	logic       split;
	logic       early;
	logic       single;
	logic       keepCrc;
	logic       accept;

	assign idle    = (s.rxSt == RX_IDLE);
	assign split   = s.rxCtl[`MSCFG_RX_SPLIT];
	assign early   = split && s.rxCtl[`MSCFG_RX_SHARED];
	assign single  = !split && s.rxCtl[`MSCFG_RX_SHARED];
	assign keepCrc = s.rxCtl[`MSCFG_RX_CRC] || split || s.rxCtl[`MSCFG_RX_ALL];
	assign accept  = s.toB ? s.rxCtl[`MSCFG_RX_B_ON] : s.rxCtl[`MSCFG_RX_A_ON];

	generate
		for (genvar k = 0; k < 6; k++) begin : g_tx
			localparam int THR = (k < 4) ? k : k + 2;
			localparam int OFF = (k < 4) ? k + 4 : k - 2;
			assign txReady[k] = txRequest[k] && !s.txCtl[OFF]
				&& (txFifoBytes[k] >= threshBytes(s.thr[THR]) || txWholeFrame[k]);
		end
	endgenerate

	// at frame start the header decision; later the remainder of a split frame
	mscfg_rx_steer i_mscfg_rx_steer (
		.frameType (idle ? rxType : s.rxType),
		.filterA   (s.filt[0]),
		.filterB   (s.filt[1]),
		.acceptA   (s.rxCtl[`MSCFG_RX_A_ON]),
		.acceptB   (s.rxCtl[`MSCFG_RX_B_ON]),
		.isOwn     (idle && rxOwn),
		.ownOn     (s.rxCtl[`MSCFG_RX_OWN]),
		.inHeader  (idle && split),
		.toB       (stToB),
		.store     (stStore),
		.abort     (stAbort)
	);

	always_comb begin
		n = s;
		n.txStart   = '0;
		n.pushValid = 1'b0;
		n.abortMac  = 1'b0;
		n.hdrRel    = 1'b0;
		n.hdrErr    = 1'b0;
		n.frameDone = 1'b0;
		if (bus.clearErrors) begin
			n.parErr    = 1'b0;
			n.abortSeen = 1'b0;
		end
		if (bus.regWr) begin
			if (bus.regType == `MSCFG_T_CTL && bus.regIndex == `MSCFG_I_TXCTL) begin
				n.txCtl = bus.regData & `MSCFG_TXCTL_MASK;
			end else if (bus.regType == `MSCFG_T_CTL && bus.regIndex == `MSCFG_I_RXCTL) begin
				n.rxCtl = bus.regData;
			end else if (bus.regType == `MSCFG_T_CTL && bus.regIndex[2:1] == `MSCFG_I_RX_HI) begin
				n.filt[bus.regIndex[0]] = bus.regData & `MSCFG_FILTER_MASK;
			end else if (bus.regType == `MSCFG_T_HDR && bus.regIndex == `MSCFG_I_FIFO_A) begin
				n.hdr = bus.regData;
			end else if (bus.regType == `MSCFG_T_BUF && bus.regIndex[2:1] == `MSCFG_I_RX_HI) begin
				n.bufSz[bus.regIndex[0]] = bus.regData;
			end else if (bus.regType == `MSCFG_T_THR) begin
				n.thr[bus.regIndex] = bus.regData;
			end else if (bus.regType == `MSCFG_T_CAP && bus.regIndex < `MSCFG_CAP_COUNT) begin
				n.cap[bus.regIndex] = bus.regData[6:0];
			end else if (bus.regType == `MSCFG_T_QUOTA && bus.regIndex[2:1] == `MSCFG_I_RX_HI) begin
				n.quota[bus.regIndex[0]] = bus.regData;
			end
		end

		for (int k = 0; k < 6; k++) begin
			n.capReached[k] = localFrames[k] > {1'b0, s.cap[k]};
		end
		for (int j = 0; j < 2; j++) begin
			n.drainOk[j]   = rxFifoBytes[j] >= threshBytes(s.thr[4 + j]) || rxWholeFrame[j];
			n.quotaFull[j] = rxRingUsed[j] >= quotaBytes(s.quota[j]);
		end

		case (s.txSt)
			TX_IDLE: begin
				if (s.txCtl[`MSCFG_TX_ON] && |txReady) begin
					n.txStart = txReady & (~txReady + 6'h01);
					n.txSt    = TX_SEND;
					n.txBusy  = 1'b1;
				end
			end
			TX_SEND: begin
				// enable is not looked at here: a started frame always completes
				if (txFrameDone) begin
					n.txSt   = TX_IDLE;
					n.txBusy = 1'b0;
				end
			end
			default: n.txSt = TX_IDLE;
		endcase

		case (s.rxSt)
			RX_IDLE: begin
				if (rxStart) begin
					n.rxType = rxType;
					if (rxRemnant && !s.rxCtl[`MSCFG_RX_ALL]) begin
						n.rxSt = RX_DROP;
					end else if (stAbort) begin
						n.abortMac = 1'b1;
						n.rxSt     = RX_DROP;
					end else if (stStore) begin
						n.rxSt  = RX_RECV;
						n.toB   = stToB;
						n.inHdr = split;
						n.cnt   = '0;
					end else begin
						n.rxSt = RX_DROP;
					end
				end
			end
			RX_RECV: begin
				if (rxAborted) begin
					n.hdrErr = split && !early;
					n.rxSt   = RX_IDLE;
				end else if (!accept) begin
					n.abortMac = 1'b1;
					n.hdrErr   = split && !early;
					n.rxSt     = RX_DROP;
				end else if (rxByteValid && s.rxCtl[`MSCFG_RX_PARITY]
					&& !(^{rxByte, rxParity})) begin
					n.abortMac = 1'b1;
					n.parErr   = 1'b1;
					n.hdrErr   = split && !early;
					n.rxSt     = RX_DROP;
				end else begin
					if (rxByteValid && !(rxCrc && !keepCrc)
						&& !(single && s.cnt >= sizeBytes(s.bufSz[s.toB], `MSCFG_BUF_UNIT))) begin
						n.pushValid  = 1'b1;
						n.pushToB    = s.toB;
						n.pushData   = rxByte;
						// stored parity: received when checked, made here otherwise
						n.pushParity = s.rxCtl[`MSCFG_RX_PARITY] ? rxParity : ~^rxByte;
						n.cnt        = s.cnt + 14'h0001;
						if (s.inHdr && n.cnt == sizeBytes(s.hdr, `MSCFG_HDR_UNIT)) begin
							n.inHdr  = 1'b0;
							n.toB    = stToB;
							n.hdrRel = early;
						end
					end
					if (rxEnd) begin
						n.frameDone   = 1'b1;
						n.frameLength = n.cnt;
						n.hdrRel      = split && (!early || n.inHdr);
						n.rxSt        = RX_IDLE;
					end
				end
			end
			RX_DROP: begin
				if (rxEnd || rxAborted) begin
					n.rxSt = RX_IDLE;
				end
			end
			default: n.rxSt = RX_IDLE;
		endcase

		if (n.abortMac) begin
			n.abortSeen = 1'b1;
		end
		n.status = {4'h0, n.abortSeen, n.parErr, n.rxSt != RX_IDLE, n.txBusy};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s      <= '0;
			s.txSt <= TX_IDLE;
			s.rxSt <= RX_IDLE;
		end else begin
			s <= n;
		end
	end

	assign bus.devStatus     = s.status;
	assign txStart           = s.txStart;
	assign txBusy            = s.txBusy;
	assign capReached        = s.capReached;
	assign rxDrainOk         = s.drainOk;
	assign quotaFull         = s.quotaFull;
	assign pushValid         = s.pushValid;
	assign pushToB           = s.pushToB;
	assign pushData          = s.pushData;
	assign pushParity        = s.pushParity;
	assign receiveAbortToMac = s.abortMac;
	assign headerRelease     = s.hdrRel;
	assign headerError       = s.hdrErr;
	assign frameDone         = s.frameDone;
	assign frameLength       = s.frameLength;
endmodule

// File: hdl/mscfg_host_end.sv
// Purpose: controller end; software port to the MAC-side registers
// Assumes: software strobes are one cycle and never together
// Notes:   register reads come from a shadow, status from the device, so data is ready one cycle later
`timescale 1ns/1ps
module mscfg_host_end import mscfg_pkg::*; (
	input  wire logic       mclk,   // clock, 100 MHz
	input  wire logic       rst,    // synchronous reset, high
	input  wire logic [7:0] addr,   // {0,type,index} or status at 0x80
	input  wire logic [7:0] wdata,  // write data
	input  wire logic       wr,     // write strobe
	input  wire logic       rd,     // read strobe
	output logic [7:0]      rdata,  // read data, cycle after rd
	mscfg_link_if.host      bus     // register path
);
	mscfg_host_t s;
	mscfg_host_t n;
	logic        loc;

	// software must itself; values pass unchecked
	assign loc = !addr[7] && validLoc(addr[6:3], addr[2:0]);

	always_comb begin
		n             = s;
		n.regWr       = 1'b0;
		n.clearErrors = 1'b0;
		n.rdata       = `MSCFG_RST_VALUE;
		if (wr && loc) begin
			n.shadow[addr[6:0]] = wdata & maskOf(addr[6:3], addr[2:0]);
			n.regWr             = 1'b1;
			n.regType           = addr[6:3];
			n.regIndex          = addr[2:0];
			n.regData           = wdata;
		end else if (wr && addr == `MSCFG_HOST_STATUS) begin
			n.clearErrors = 1'b1;
		end
		if (rd && loc) begin
			n.rdata = s.shadow[addr[6:0]];
		end else if (rd && addr == `MSCFG_HOST_STATUS) begin
			n.rdata = bus.devStatus;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rdata           = s.rdata;
	assign bus.regWr       = s.regWr;
	assign bus.regType     = s.regType;
	assign bus.regIndex    = s.regIndex;
	assign bus.regData     = s.regData;
	assign bus.clearErrors = s.clearErrors;
endmodule

// File: tb/mscfg_link_sva.sv
// Purpose: checks transmit and receive timing of the joined ends
// Assumes: one clock, synchronous reset
// Notes:   link signals plus a few device pins as plain inputs
`timescale 1ns/1ps
module mscfg_link_sva (
	input wire logic       mclk,              // clock
	input wire logic       rst,               // reset, high
	input wire logic       regWr,             // link write pulse
	input wire logic [3:0] regType,           // link register type
	input wire logic [2:0] regIndex,          // link register index
	input wire logic [7:0] regData,           // link write data
	input wire logic [5:0] txStart,           // channel start pulse
	input wire logic       txBusy,            // frame in progress
	input wire logic       txFrameDone,       // MAC finished frame
	input wire logic       frameDone,         // frame stored
	input wire logic       rxEnd,             // frame end from MAC
	input wire logic       pushValid,         // byte stored
	input wire logic       receiveAbortToMac  // abort to MAC
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_txQuiet;
		(txStart == 6'h00) [*4];
	endsequence
	// old enable may still launch one start on the write edge
	sequence s_txOffWrite;
		regWr && regType == 4'h1 && regIndex == 3'h0 && !regData[0] && !txBusy;
	endsequence

	property p_startOneHot;
		txStart != 6'h00 |-> $onehot(txStart) && txBusy;
	endproperty
	a_startOneHot: assert property (p_startOneHot) else $error("start not one-hot");
	property p_noStartBusy;
		txStart != 6'h00 |-> !$past(txBusy);
	endproperty
	a_noStartBusy: assert property (p_noStartBusy) else $error("start while busy");
	property p_busyRise;
		$rose(txBusy) |-> txStart != 6'h00;
	endproperty
	a_busyRise: assert property (p_busyRise) else $error("busy without start");
	property p_globalOff;
		s_txOffWrite |-> ##2 s_txQuiet;
	endproperty
	a_globalOff: assert property (p_globalOff) else $error("start after global off");
	property p_busyEnd;
		txBusy && txFrameDone |=> !txBusy;
	endproperty
	a_busyEnd: assert property (p_busyEnd) else $error("busy after frame done");
	property p_busyHold;
		txBusy && !txFrameDone |=> txBusy;
	endproperty
	a_busyHold: assert property (p_busyHold) else $error("busy dropped mid frame");
	property p_doneAfterEnd;
		frameDone |-> $past(rxEnd);
	endproperty
	a_doneAfterEnd: assert property (p_doneAfterEnd) else $error("done without end");
	property p_abortDrops;
		receiveAbortToMac |=> (!pushValid) [*2];
	endproperty
	a_abortDrops: assert property (p_abortDrops) else $error("store after abort");
endmodule

// File: tb/mscfg_bench.sv
// Purpose: self-checking bench of both ends joined by the link
// Assumes: software strobes one cycle, driven just after the edge
// Notes:   owner, remnant, abort and whole-frame inputs held low
`timescale 1ns/1ps
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin failCount++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module mscfg_bench;
	logic             mclk, rst, wr, rd, txFrameDone, rxStart, rxByteValid;
	logic             rxParity, rxCrc, rxEnd, txBusy, pushValid, pushToB;
	logic             receiveAbortToMac, frameDone, lastToB, headerRelease, pushParity;
	logic [7:0]       addr, wdata, rdata, rxByte, pushData;
	logic [5:0]       txRequest, txStart, capReached;
	logic [5:0][13:0] txFifoBytes;
	logic [5:0][7:0]  localFrames;
	logic [1:0][13:0] rxFifoBytes, rxRingUsed;
	logic [1:0]       rxDrainOk, quotaFull;
	logic [2:0]       rxType;
	logic [13:0]      frameLength, lastLen;
	int               failCount, numChecks, pushes, aborts, dones, rels;

	mscfg_link_if link ();
	mscfg_host_end i_mscfg_host_end (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .bus(link));
	mscfg_device_end i_mscfg_device_end (.mclk, .rst, .bus(link), .txRequest, .txFifoBytes,
		.txWholeFrame(6'h00), .txFrameDone, .localFrames, .rxFifoBytes, .rxWholeFrame(2'h0),
		.rxRingUsed, .rxStart, .rxType, .rxOwn(1'h0), .rxRemnant(1'h0), .rxByteValid, .rxByte,
		.rxParity, .rxCrc, .rxEnd, .rxAborted(1'h0), .txStart, .txBusy, .capReached, .rxDrainOk,
		.quotaFull, .pushValid, .pushToB, .pushData, .pushParity, .receiveAbortToMac,
		.headerRelease, .headerError(), .frameDone, .frameLength);
	mscfg_link_sva i_mscfg_link_sva (.mclk, .rst, .regWr(link.regWr), .regType(link.regType),
		.regIndex(link.regIndex), .regData(link.regData), .txStart, .txBusy, .txFrameDone,
		.frameDone, .rxEnd, .pushValid, .receiveAbortToMac);

	always #5 mclk = ~mclk;

	always @(posedge mclk) begin
		if (pushValid === 1'h1) begin
			`CHK(pushData, 8'h10 + 8'(pushes))
			`CHK(^{pushData, pushParity}, 1'h1)
			pushes++;
			lastToB = pushToB;
		end
		if (receiveAbortToMac === 1'h1) aborts++;
		if (headerRelease === 1'h1) rels++;
		if (frameDone === 1'h1) begin
			dones++;
			lastLen = frameLength;
		end
	end

	task automatic endSim;
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// returns on the edge the device register takes the value
	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge mclk);
		wr <= 1'h0;
		@(posedge mclk);
	endtask

	task automatic regRead(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask

	task automatic settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic waitStart(input logic [5:0] e);
		int i;
		i = 0;
		while (txStart === 6'h00 && i < 20) begin
			@(posedge mclk);
			#1 i++;
		end
		if (i == 20) begin
			failCount++;
			endSim();
		end
		`CHK(txStart, e)
	endtask

	task automatic pulseDone;
		@(posedge mclk);
		txFrameDone <= 1'h1;
		@(posedge mclk);
		txFrameDone <= 1'h0;
		settle();
	endtask

	task automatic frame(input logic [2:0] t, input int n, input int crcN, input bit bad);
		logic [7:0] b;
		#1;
		pushes = 0;
		aborts = 0;
		dones = 0;
		rels = 0;
		lastLen = 14'h0000;
		@(posedge mclk);
		rxStart <= 1'h1;
		rxType <= t;
		for (int i = 0; i < n; i++) begin
			b = 8'h10 + 8'(i);
			@(posedge mclk);
			rxStart <= 1'h0;
			rxByteValid <= 1'h1;
			rxByte <= b;
			rxParity <= ~^b ^ (bad && i == 0);
			rxCrc <= (i >= n - crcN);
			rxEnd <= (i == n - 1);
		end
		@(posedge mclk);
		rxByteValid <= 1'h0;
		rxCrc <= 1'h0;
		rxEnd <= 1'h0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic testRegs;
		logic [7:0] tbl [5][3];
		logic [7:0] d;
		tbl = '{'{8'h08, 8'hFF, 8'hFD}, '{8'h0C, 8'hFF, 8'hBF}, '{8'h28, 8'hFF, 8'h7F},
			'{8'h14, 8'h10, 8'h10}, '{8'h30, 8'h55, 8'h00}};
		foreach (tbl[i]) begin
			regWrite(tbl[i][0], tbl[i][1]);
			regRead(tbl[i][0], d);
			`CHK(d, tbl[i][2])
		end
		$display("test registers done");
	endtask

	task automatic testTx;
		regWrite(8'h08, 8'h00);
		regWrite(8'h20, 8'h02);
		regWrite(8'h21, 8'h02);
		regWrite(8'h08, 8'h01);
		txRequest <= 6'h01;
		txFifoBytes[0] <= 14'h003F;
		settle();
		`CHK(txBusy, 1'h0)
		@(posedge mclk);
		txFifoBytes[0] <= 14'h0040;
		waitStart(6'h01);
		regWrite(8'h08, 8'h00);
		`CHK(txBusy, 1'h1)
		pulseDone();
		`CHK(txBusy, 1'h0)
		@(posedge mclk);
		txRequest <= 6'h03;
		txFifoBytes[1] <= 14'h0040;
		// channel 0 disabled, channel 1 must still go
		regWrite(8'h08, 8'h11);
		waitStart(6'h02);
		// drop requests first so the finished frame is not followed by another
		@(posedge mclk);
		txRequest <= 6'h00;
		pulseDone();
		$display("test transmit done");
	endtask

	task automatic testLevels;
		regWrite(8'h28, 8'h00);
		regWrite(8'h2D, 8'h7F);
		regWrite(8'h24, 8'hE6);
		regWrite(8'h64, 8'h0A);
		localFrames[0] <= 8'h01;
		localFrames[5] <= 8'h7F;
		rxFifoBytes[0] <= 14'h1CBF;
		rxRingUsed[0] <= 14'h015F;
		settle();
		`CHK(capReached, 6'h01)
		`CHK(rxDrainOk[0], 1'h0)
		`CHK(quotaFull[0], 1'h0)
		@(posedge mclk);
		localFrames[5] <= 8'h80;
		rxFifoBytes[0] <= 14'h1CC0;
		rxRingUsed[0] <= 14'h0160;
		settle();
		`CHK(capReached, 6'h21)
		`CHK(rxDrainOk[0], 1'h1)
		`CHK(quotaFull[0], 1'h1)
		$display("test levels done");
	endtask

	task automatic testRx;
		logic [7:0] d;
		regWrite(8'h0C, 8'h08);
		regWrite(8'h0D, 8'h0A);
		regWrite(8'h09, 8'h03);
		frame(3'h3, 3, 0, 0);
		`CHK(lastToB, 1'h0)
		`CHK(lastLen, 14'h0003)
		frame(3'h1, 2, 0, 0);
		`CHK(lastToB, 1'h1)
		frame(3'h2, 2, 0, 0);
		`CHK(pushes + dones, 0)
		frame(3'h3, 6, 4, 0);
		`CHK(lastLen, 14'h0002)
		regWrite(8'h09, 8'h0B);
		frame(3'h3, 6, 4, 0);
		`CHK(lastLen, 14'h0006)
		regWrite(8'h09, 8'h83);
		frame(3'h3, 3, 0, 1);
		`CHK(aborts, 1)
		`CHK(pushes, 0)
		regWrite(8'h09, 8'h02);
		frame(3'h3, 2, 0, 0);
		`CHK(aborts, 1)
		`CHK(pushes, 0)
		regWrite(8'h1C, 8'h01);
		regWrite(8'h09, 8'h07);
		frame(3'h3, 70, 0, 0);
		`CHK(lastLen, 14'h0040)
		regWrite(8'h1C, 8'h00);
		regWrite(8'h14, 8'h01);
		regWrite(8'h09, 8'h47);
		frame(3'h1, 40, 4, 0);
		`CHK(lastToB, 1'h1)
		`CHK(lastLen, 14'h0028)
		`CHK(rels, 1)
		regRead(8'h80, d);
		`CHK(d, 8'h0C)
		regWrite(8'h80, 8'h00);
		regRead(8'h80, d);
		`CHK(d, 8'h00)
		$display("test receive done");
	endtask

	initial begin
		mclk = 1'h0;
		rst = 1'h1;
		{wr, rd, txFrameDone, rxStart, rxByteValid, rxParity, rxCrc, rxEnd} = 8'h00;
		{addr, wdata, rxByte, rxType, txRequest} = '0;
		{txFifoBytes, localFrames, rxFifoBytes, rxRingUsed} = '0;
		failCount = 0;
		numChecks = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'h0;
		testRegs();
		testTx();
		testLevels();
		testRx();
		endSim();
	end

	initial begin
		repeat (50000) @(posedge mclk);
		failCount++;
		endSim();
	end
endmodule
